// ---- pfc_pad.sv ----
`timescale 1ns/10ps
// =====================================================
// per-pin pad control: pull, slew, drive gating
module pfc_pad
  import pfc_pkg::*;
(
  input  wire logic pull_en,   // software pull enable
  input  wire logic slew_en,   // software slew enable
  input  wire logic drive_hi,  // software drive select
  input  wire logic is_out,    // pin driven by port or peripheral
  input  wire logic is_analog, // analog function owns pin
  input  wire logic rise_det,  // rising-edge detect active
  input  wire logic force_pu,  // reset or debug function pull-up
  output logic      pu_on,     // pull-up active
  output logic      pd_on,     // pulldown active
  output logic      slew_on,   // slew limit active
  output logic      hd_on      // high drive active
);
  wire pull_ok = pull_en & ~is_out & ~is_analog; // [R15]
  assign pu_on   = force_pu | (pull_ok & ~rise_det); // [R16]
  assign pd_on   = ~force_pu & pull_ok & rise_det; // [R16]
  assign slew_on = slew_en & is_out; // [R17]
  assign hd_on   = drive_hi & is_out; // [R18]
endmodule

// ---- pfc_pins.sv ----
`timescale 1ns/10ps
// =====================================================
// board side of the shared reset pin and the debug pin
module pfc_pins (
  input  wire logic debug_oe,     // device drives debug pin
  input  wire logic debug_out,    // device level on debug pin
  input  wire logic pull_dbg,     // device pull-up on debug pin
  input  wire logic host_low,     // debug host holds mode pin low
  input  wire logic pull_rst,     // device pull-up on reset pin
  input  wire logic ext_low,      // board drives reset pin low
  input  wire logic ext_high,     // board drives reset pin high
  output logic      debug_pin_in, // resolved debug wire
  output logic      reset_pin_in  // resolved reset wire
);
  logic flip; // floating wire pattern, never a stable guess
  // =====================================================
  // undriven, unpulled lines wander every 37 ns
  initial begin
    flip = 1'b0;
    forever #37 flip = ~flip;
  end
  // host only ever pulls low; device low or speed-up high wins otherwise
  assign debug_pin_in = (debug_oe & ~debug_out) | host_low ? 1'b0 :
                        (debug_oe | pull_dbg) ? 1'b1 : flip;
  // external driver, else pull-up, else floating
  assign reset_pin_in = ext_low ? 1'b0 : ext_high ? 1'b1 : pull_rst ? 1'b1 : flip;
endmodule

// ---- pfc_pkg.sv ----
// Overview of operation
// R1: all control registers clocked by bus clock
// R2: clock generator defaults 16 MHz, bus 4 MHz
// R3: user-mode power-on: reset pin is port input
// R4: reset-pin enable sticks until power-on
// R5: reset function: low resets, pull-up on
// R6: background power-on: shared pin is reset input
// R7: timer2 capture mode uses shared pin input
// R8: mode-select during reset, debug pin afterwards
// R9: debug enable set each reset, pull-up on
// R10: low mode pin at reset forces background
// R11: debug bit time is sixteen clocks
// R12: pseudo open-drain with brief high speed-up pulse
// R13: after reset inputs hi-z, pull-ups off
// R14: output-only pin low drive, slew on
// R15: pull-up only for enabled input pins
// R16: rising-edge detection turns pull-up into pulldown
// R17: slew bit only affects output pins
// R18: drive bit selects high drive
// R19: pad bits separate from port registers
// R20: highest priority function owns the pin
// R21: reset pin never enters background mode
// R22: high mode pin at reset gives run mode
// R23: unspecified pad control bits reset zero
package pfc_pkg;
  // =====================================================
  // clocking and reset defaults
  localparam int          PFC_MCLK_HZ       = 40_000_000;
  localparam int          PFC_ICG_HZ        = 16_000_000;
  localparam int          PFC_BUS_HZ        = 4_000_000;
  localparam int          PFC_BUS_DIV       = PFC_MCLK_HZ / PFC_BUS_HZ;
  localparam int          PFC_ICG_DIV       = PFC_ICG_HZ / PFC_BUS_HZ;
  localparam int          PFC_BIT_CYCLES    = 16;
  localparam int          PFC_SPEEDUP_CYC   = 1;
  localparam int          PFC_NPINS         = 6;
  localparam logic [5:0]  PFC_PAD_RST       = 6'h00;
  localparam logic [5:0]  PFC_SLEW_RST      = 6'h10;
  localparam int          PFC_OUTONLY_IDX   = 4;
  localparam logic [15:0] PFC_RUN_VECTOR    = 16'hFFFE;
  // pin ownership, lowest to highest priority
  typedef enum logic [1:0] {PFC_OWN_PORT, PFC_OWN_ALT1, PFC_OWN_ALT2, PFC_OWN_ALT3} pfc_own_type;
  typedef enum logic {PFC_MODE_RUN, PFC_MODE_BACKGROUND} pfc_mode_type;
endpackage

// ---- pfc_top.sv ----
`timescale 1ns/10ps
// =====================================================
// pin function selection and pad control
module pfc_top
  import pfc_pkg::*;
#(
  parameter int NPINS = PFC_NPINS
)(
  input  wire logic             mclk,          // 40 MHz
  input  wire logic             rst,           // async, high
  input  wire logic             por,           // power-on reset pulse, synchronous
  input  wire logic             force_reset,   // debug force reset request
  input  wire logic             wr_en,         // software write strobe
  input  wire logic             reset_pin_function_enable_wr, // write value
  input  wire logic             debug_pin_function_enable_wr,
  input  wire logic [NPINS-1:0] pull_wr,       // pull-up enable bits
  input  wire logic [NPINS-1:0] slew_wr,       // slew bits
  input  wire logic [NPINS-1:0] drive_wr,      // drive bits
  input  wire logic             timer2_capture_mode,
  input  wire logic             irq_enable,    // irq function on shared pin
  input  wire logic [NPINS-1:0] port_dir_out,  // port direction
  input  wire logic [NPINS-1:0] periph_out,    // peripheral drives pin
  input  wire logic [NPINS-1:0] analog_own,    // analog function owns pin
  input  wire logic [NPINS-1:0] rise_detect,   // kbi/irq rising edge
  input  wire logic             reset_pin_in,  // shared reset pin level
  input  wire logic             debug_pin_in,  // debug pin level
  input  wire logic             debug_tx_go,   // start debug bit
  input  wire logic             debug_tx_bit,  // bit value
  output logic                  system_bus_clock_en, // bus-rate enable
  output logic                  reset_fn_q,    // shared pin is reset input
  output logic                  debug_pin_function_enable_q,
  output logic                  ext_reset_req, // external reset request
  output logic                  timer2_capture_input,
  output logic                  mode_background, // active background mode
  output logic [15:0]           run_vector,
  output logic                  debug_out,
  output logic                  debug_oe,
  output logic                  debug_busy,
  output logic [NPINS-1:0]      pu_on,
  output logic [NPINS-1:0]      pd_on,
  output logic [NPINS-1:0]      slew_on,
  output logic [NPINS-1:0]      hd_on
);
  // =====================================================
  // bus clock enable divider
  logic [3:0] div_q;          // divider count
  wire        div_end = (div_q == 4'(PFC_BUS_DIV - 1));
  always_ff @(posedge mclk or posedge rst) begin // [R2]
    if (rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_end ? 4'h0 : div_q + 4'h1;
    end
  end
  assign system_bus_clock_en = div_end;
  // =====================================================
  // pin synchronisers
  logic [1:0] rs_q;  // reset pin sync
  logic [1:0] ds_q;  // debug pin sync
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rs_q <= 2'b11;
      ds_q <= 2'b11;
    end else begin
      rs_q <= {rs_q[0], reset_pin_in};
      ds_q <= {ds_q[0], debug_pin_in};
    end
  end
  wire rst_pin_s = rs_q[1];
  wire dbg_pin_s = ds_q[1];
  // =====================================================
  // mode sample and reset-pin function
  logic in_reset_q; // mode-select phase during por/force reset
  logic sample_q;   // pending mode sample
  logic bgm_q;
  logic from_por_q; // last reset was power-on, not a debug force reset
  wire  mode_phase = por | force_reset;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_reset_q <= 1'b1;
      sample_q   <= 1'b0;
      bgm_q      <= 1'b0;
      from_por_q <= 1'b1;
    end else begin
      in_reset_q <= mode_phase;
      // of the resets, only a power-on into background hands the shared pin to reset; a software write can also set it
      if (por) begin
        from_por_q <= 1'b1; // [R6]
      end else if (force_reset) begin
        from_por_q <= 1'b0;
      end
      sample_q   <= in_reset_q & ~mode_phase;
      // pin sampled at reset release; low means background
      if (sample_q) begin
        bgm_q <= ~dbg_pin_s; // [R10] [R22]
      end
    end
  end
  assign mode_background = bgm_q;
  assign run_vector      = PFC_RUN_VECTOR; // [R22]
  // external reset pin only clears to user mode: it never samples mode [R21]
  always_ff @(posedge mclk or posedge rst) begin // [R1]
    if (rst) begin
      reset_fn_q <= 1'b0; // [R3]
    end else if (por) begin
      reset_fn_q <= 1'b0; // [R3]
    end else if (sample_q & ~dbg_pin_s & from_por_q) begin
      reset_fn_q <= 1'b1; // [R6]
    end else if (wr_en & system_bus_clock_en & reset_pin_function_enable_wr) begin
      reset_fn_q <= 1'b1; // sticky until power-on [R4]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin // [R1]
    if (rst) begin
      debug_pin_function_enable_q <= 1'b1; // [R9]
    end else if (mode_phase) begin
      debug_pin_function_enable_q <= 1'b1; // [R9]
    end else if (wr_en & system_bus_clock_en) begin
      debug_pin_function_enable_q <= debug_pin_function_enable_wr;
    end
  end
  assign ext_reset_req        = reset_fn_q & ~rst_pin_s; // [R5]
  assign timer2_capture_input = timer2_capture_mode & ~reset_fn_q & ~irq_enable & rst_pin_s; // [R7] [R20]
  // =====================================================
  // pad control registers, separate from port registers
  logic [NPINS-1:0] pull_q;
  logic [NPINS-1:0] slew_q;
  logic [NPINS-1:0] drive_q;
  always_ff @(posedge mclk or posedge rst) begin // [R19]
    if (rst) begin
      pull_q  <= PFC_PAD_RST; // [R13] [R23]
      slew_q  <= PFC_SLEW_RST; // [R14]
      drive_q <= PFC_PAD_RST; // [R14] [R23]
    end else if (wr_en & system_bus_clock_en) begin
      pull_q  <= pull_wr;
      slew_q  <= slew_wr;
      drive_q <= drive_wr;
    end
  end
  // =====================================================
  // debug speed-up transmitter, one bit per sixteen bus ticks
  logic [4:0] bit_cnt_q;
  logic       tx_bit_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 5'h00;
      tx_bit_q  <= 1'b1;
    end else if (bit_cnt_q == 5'h00) begin
      if (debug_tx_go & debug_pin_function_enable_q & ~in_reset_q) begin
        bit_cnt_q <= 5'(PFC_BIT_CYCLES); // [R11]
        tx_bit_q  <= debug_tx_bit;
      end
    end else if (system_bus_clock_en) begin
      bit_cnt_q <= bit_cnt_q - 5'h01;
    end
  end
  // low phase for first quarter (one) or three quarters (zero)
  wire [4:0] low_end = tx_bit_q ? 5'(PFC_BIT_CYCLES - 4) : 5'(PFC_BIT_CYCLES - 12);
  wire busy  = (bit_cnt_q != 5'h00);
  wire low_p = busy & (bit_cnt_q > low_end);
  wire spd_p = busy & (bit_cnt_q == low_end); // speed-up high tick [R12]
  assign debug_busy = busy;
  assign debug_out  = spd_p; // [R12]
  assign debug_oe   = low_p | spd_p; // [R12]
  // =====================================================
  // per-pin pad gating
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pad
      wire fpu = (gi == 5) ? reset_fn_q : (gi == 4) ? debug_pin_function_enable_q : 1'b0; // [R5] [R9]
      pfc_pad u_pad (
        .pull_en  (pull_q[gi]),
        .slew_en  (slew_q[gi]),
        .drive_hi (drive_q[gi]),
        .is_out   (port_dir_out[gi] | periph_out[gi]),
        .is_analog(analog_own[gi]),
        .rise_det (rise_detect[gi]),
        .force_pu (fpu),
        .pu_on    (pu_on[gi]),
        .pd_on    (pd_on[gi]),
        .slew_on  (slew_on[gi]),
        .hd_on    (hd_on[gi])
      );
    end
  endgenerate
  // =====================================================
  // checks
  sticky_reset_a: assert property (@(posedge mclk) disable iff (rst)
    $past(reset_fn_q) && !$past(por) |-> reset_fn_q) else $error("reset function lost"); // [R4]
  ext_reset_a: assert property (@(posedge mclk) disable iff (rst)
    ext_reset_req |-> reset_fn_q && !rst_pin_s) else $error("bad reset request"); // [R5]
  dbg_set_a: assert property (@(posedge mclk) disable iff (rst)
    mode_phase |=> debug_pin_function_enable_q) else $error("debug enable not set"); // [R9]
  por_port_a: assert property (@(posedge mclk) disable iff (rst)
    por |=> !reset_fn_q) else $error("reset fn after por"); // [R3]
  mode_sample_a: assert property (@(posedge mclk) disable iff (rst)
    sample_q |=> mode_background == !$past(dbg_pin_s)) else $error("mode sample wrong"); // [R10]
  bit_len_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy) |-> bit_cnt_q == 5'd16) else $error("bit length"); // [R11]
  pull_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (port_dir_out[0] | periph_out[0] | analog_own[0]) |-> !pu_on[0] && !pd_on[0]) else $error("pull on out"); // [R15]
  slew_in_a: assert property (@(posedge mclk) disable iff (rst)
    !(port_dir_out[1] | periph_out[1]) |-> !slew_on[1] && !hd_on[1]) else $error("slew on input"); // [R17]
  pulldown_a: assert property (@(posedge mclk) disable iff (rst)
    pull_q[0] && rise_detect[0] && !(port_dir_out[0] | periph_out[0] | analog_own[0]) |-> pd_on[0])
    else $error("no pulldown"); // [R16]
  cap_prio_a: assert property (@(posedge mclk) disable iff (rst)
    reset_fn_q |-> !timer2_capture_input) else $error("capture over reset"); // [R20]
  bit_cov: cover property (@(posedge mclk) $fell(busy));
  bgm_cov: cover property (@(posedge mclk) $rose(mode_background));
  rfn_cov: cover property (@(posedge mclk) $rose(reset_fn_q));
endmodule

// ---- pin_function_and_pad_control_tb.sv ----
`timescale 1ns/10ps
`define CMP(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h seen %h", n, e, s); end end
module pin_function_and_pad_control_tb;
  import pfc_pkg::*;
  localparam int N = PFC_NPINS;
  logic         mclk, rst, por, force_reset, wr_en, rpe_wr, dpe_wr, go, tx_bit;
  logic         t2cap, irq_en, host_low, ext_low, ext_high;
  logic [N-1:0] pull_w, slew_w, drv_w, dir, per, ana, rise, om;
  wire          dbg_in, rst_in, bus_en, rfn, dpe, xreq, cap, mode, dout, doe, busy;
  wire  [15:0]  vec;
  wire  [N-1:0] pu, pd, sl, hd;
  int           fail_count, cmp_count, meas, i, b, k, lo, hi, n;
  typedef struct {int sel; logic [15:0] e;} pfc_note_type;
  pfc_note_type notes[$]; // expected results, oldest first
  pfc_note_type note;
  event         got;
  string        nm [11] = '{"reset_fn_q", "debug_en_q", "mode_bg", "run_vector", "pu_on", "pd_on",
                            "slew_on", "hd_on", "ext_reset_req", "capture_in", "debug_meas"};
  pfc_top DUT (.mclk(mclk), .rst(rst), .por(por), .force_reset(force_reset), .wr_en(wr_en),
    .reset_pin_function_enable_wr(rpe_wr), .debug_pin_function_enable_wr(dpe_wr), .pull_wr(pull_w),
    .slew_wr(slew_w), .drive_wr(drv_w), .timer2_capture_mode(t2cap), .irq_enable(irq_en),
    .port_dir_out(dir), .periph_out(per), .analog_own(ana), .rise_detect(rise), .reset_pin_in(rst_in),
    .debug_pin_in(dbg_in), .debug_tx_go(go), .debug_tx_bit(tx_bit), .system_bus_clock_en(bus_en),
    .reset_fn_q(rfn), .debug_pin_function_enable_q(dpe), .ext_reset_req(xreq),
    .timer2_capture_input(cap), .mode_background(mode), .run_vector(vec), .debug_out(dout),
    .debug_oe(doe), .debug_busy(busy), .pu_on(pu), .pd_on(pd), .slew_on(sl), .hd_on(hd));
  pfc_pins board (.debug_oe(doe), .debug_out(dout), .pull_dbg(pu[4]), .host_low(host_low),
    .pull_rst(pu[5]), .ext_low(ext_low), .ext_high(ext_high), .debug_pin_in(dbg_in), .reset_pin_in(rst_in));
  // =====================================================
  // clock, watchdog, helpers
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // whole run is under a thousand cycles; five thousand means a hang
  initial begin
    #125000;
    fail_count++;
    results();
  end
  function automatic logic [15:0] obs(int s);
    case (s)
      0: return 16'(rfn);
      1: return 16'(dpe);
      2: return 16'(mode);
      3: return vec;
      4: return 16'(pu);
      5: return 16'(pd);
      6: return 16'(sl);
      7: return 16'(hd & om); // drive only matters on outputs
      8: return 16'(xreq);
      9: return 16'(cap);
      default: return 16'(meas);
    endcase
  endfunction
  // monitor: drains all pending notes, oldest first, whenever a result is posted
  always @(got) begin
    while (notes.size() > 0) begin
      note = notes.pop_front();
      `CMP(nm[note.sel], note.e, obs(note.sel))
    end
  end
  task automatic chk(int sel, logic [15:0] e);
    notes.push_back('{sel, e});
    ->got;
    #1;
  endtask
  task automatic step(int c);
    repeat (c) @(posedge mclk);
    #2;
  endtask
  // write lands only on a bus-rate edge, so hold until one passes
  task automatic wr(logic rp, logic dp, logic [N-1:0] p, logic [N-1:0] s, logic [N-1:0] d);
    int j;
    {rpe_wr, dpe_wr, pull_w, slew_w, drv_w, wr_en} = {rp, dp, p, s, d, 1'b1};
    for (j = 0; j < 20 && bus_en !== 1'b1; j++) step(1);
    step(1);
    wr_en = 1'b0;
    step(1);
  endtask
  // power-on or forced reset, optional host holding the mode pin low
  task automatic do_por(logic lo_pin, logic frc);
    host_low = lo_pin;
    if (frc) force_reset = 1'b1;
    else por = 1'b1;
    step(4);
    {por, force_reset} = 2'b00;
    step(6);
    host_low = 1'b0;
    step(2);
  endtask
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial begin
    {rst, por, force_reset, wr_en, rpe_wr, dpe_wr, go, tx_bit, t2cap, irq_en, host_low, ext_low, ext_high} = '0;
    {pull_w, slew_w, drv_w, dir, per, ana, rise, om} = '0;
    {fail_count, cmp_count, meas} = '0;
    rst = 1'b1;
    void'($urandom(32'h0ced));
    step(8);
    rst = 1'b0;
    do_por(1'b0, 1'b0);
    chk(0, 16'h0000);
    chk(1, 16'h0001);
    chk(2, 16'h0000);
    chk(3, 16'hFFFE);
    chk(4, 16'h0010);
    chk(5, 16'h0000);
    dir = 6'h10;
    om = dir;
    step(1);
    chk(6, 16'h0010);
    chk(7, 16'h0000);
    // write strobe outside a bus-rate edge must be dropped
    for (i = 0; i < 20 && bus_en !== 1'b1; i++) step(1);
    step(1);
    {pull_w, wr_en} = {6'h0f, 1'b1};
    step(1);
    wr_en = 1'b0;
    chk(4, 16'h0010);
    // random pad settings against random pin ownership
    for (i = 0; i < 12; i++) begin
      {dir, per, ana, rise} = 24'($urandom);
      rise &= 6'h0f; // edge detect only exists on keyboard pins
      om = dir | per;
      wr(1'b0, 1'b0, 6'($urandom), 6'($urandom), 6'($urandom));
      chk(4, 16'(pull_w & ~om & ~ana & ~rise));
      chk(5, 16'(pull_w & ~om & ~ana & rise));
      chk(6, 16'(slew_w & om));
      chk(7, 16'(drv_w & om));
    end
    {dir, per, ana, rise, om} = '0;
    wr(1'b1, 1'b0, 6'h00, 6'h00, 6'h00);
    chk(0, 16'h0001);
    chk(4, 16'h0020);
    ext_low = 1'b1;
    step(4);
    chk(8, 16'h0001);
    ext_low = 1'b0;
    wr(1'b0, 1'b0, 6'h00, 6'h00, 6'h00);
    step(3);
    chk(0, 16'h0001);
    chk(8, 16'h0000);
    do_por(1'b0, 1'b0);
    chk(0, 16'h0000);
    chk(1, 16'h0001);
    do_por(1'b1, 1'b1);
    chk(2, 16'h0001);
    chk(0, 16'h0000);
    chk(1, 16'h0001);
    do_por(1'b0, 1'b1);
    chk(2, 16'h0000);
    do_por(1'b1, 1'b0);
    chk(2, 16'h0001);
    chk(0, 16'h0001);
    do_por(1'b0, 1'b0);
    chk(2, 16'h0000);
    t2cap = 1'b1;
    for (b = 0; b < 2; b++) begin
      {ext_low, ext_high} = {~b[0], b[0]};
      step(4);
      chk(9, 16'(b));
    end
    {t2cap, ext_low, ext_high} = '0;
    // one debug bit of each value: length, low time, speed-up pulse
    for (b = 0; b < 2; b++) begin
      {tx_bit, go} = {b[0], 1'b1};
      step(1);
      go = 1'b0;
      {lo, hi, n} = '0;
      for (k = 0; k < 400 && busy === 1'b1; k++) begin
        lo += int'(doe & ~dout);
        hi += int'(doe & dout);
        n++;
        step(1);
      end
      meas = int'(n > 15 * PFC_BUS_DIV && n <= 16 * PFC_BUS_DIV);
      chk(10, 16'h0001);
      meas = hi;
      chk(10, 16'(PFC_BUS_DIV * PFC_SPEEDUP_CYC));
      k = b ? 4 : 12;
      meas = int'(lo > (k - 1) * PFC_BUS_DIV && lo <= k * PFC_BUS_DIV);
      chk(10, 16'h0001);
    end
    results();
  end
endmodule
